// ---- pkg/dac_link_pkg.sv ----
package dac_link_pkg;
  // =====================================================
  // frame format
  localparam int FRAME_BITS = 24;
  localparam int CHANNELS = 40;
  localparam int CHAN_BITS = 6;
  localparam int DATA_BITS = 16;
  // frame layout: [23:22] kind, [21:16] channel, [15:0] data
  localparam int KIND_MSB = 23;
  localparam int KIND_LSB = 22;
  localparam int CHAN_MSB = 21;
  localparam int CHAN_LSB = 16;
  localparam logic [1:0] KIND_WRITE_FIRST = 2'h0;
  localparam logic [1:0] KIND_WRITE_SECOND = 2'h1;
  localparam logic [1:0] KIND_SELECT = 2'h2;
  localparam logic [1:0] KIND_READBACK = 2'h3;
  // =====================================================
  // timing, in ns, and derived cycles at core_clk
  localparam int CLK_NS = 10;
  localparam int BUSY_FALL_MAX_NS = 42;
  localparam int BUSY_LOW_MAX_NS = 1250;
  localparam int UPDATE_CYCLE_MAX_NS = 500;
  localparam int OUTPUT_RESP_MAX_NS = 3000;
  localparam int CLEAR_MAX_NS = 125;
  localparam int RESET_LOW_MIN_NS = 30;
  localparam int RESET_BUSY_MAX_NS = 400000;
  localparam int READBACK_GAP_MIN_NS = 270;
  localparam int FRAME_GAP_MIN_NS = 20;
  localparam int LOAD_AFTER_EDGE_MIN_NS = 20;
  localparam int LOAD_LOW_MIN_NS = 10;
  localparam int SCLK_PERIOD_MIN_NS = 20;
  localparam int UPDATE_CYCLES = UPDATE_CYCLE_MAX_NS / CLK_NS;
  localparam int RESET_BUSY_CYCLES = RESET_BUSY_MAX_NS / CLK_NS;
  localparam int READBACK_GAP_CYCLES =
    (READBACK_GAP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_GAP_CYCLES = (FRAME_GAP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_WAIT_CYCLES =
    (LOAD_AFTER_EDGE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_LOW_CYCLES = (LOAD_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_CYCLES =
    (SCLK_PERIOD_MIN_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int RESET_LOW_CYCLES =
    (RESET_LOW_MIN_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ---- pkg/dac_link_if.sv ----
`timescale 1ns/1ps
interface dac_link_if;
  logic frame_n;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic load_outputs_n;
  logic clear_outputs_n;
  logic dev_reset_n;
  logic busy_dev_o;
  logic busy_dev_oe_n;
  logic busy_host_o;
  logic busy_host_oe_n;
  logic busy;
  // open-drain wire with pull-up: low when any driver pulls low
  assign busy = !((!busy_dev_oe_n && !busy_dev_o) ||
                  (!busy_host_oe_n && !busy_host_o));
  modport device(
    input frame_n, sclk, serial_in, load_outputs_n, clear_outputs_n,
    input dev_reset_n, busy,
    output serial_out, busy_dev_o, busy_dev_oe_n
  );
  modport host(
    output frame_n, sclk, serial_in, load_outputs_n, clear_outputs_n,
    output dev_reset_n, busy_host_o, busy_host_oe_n,
    input serial_out, busy
  );
endinterface

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  // reset to ones: every synced pin here except serial_in idles high
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- rtl/dac_link_device.sv ----
`timescale 1ns/1ps
// Operation
// [R1] sample serial_in on falling sclk
// [R2] host holds serial_in stable at fall
// [R3] serial_out changes on rising sclk
// [R4] frame_n low across whole frame
// [R5] 24 falls; act on frame_n rise
// [R6] readback frames separated by 270 ns
// [R7] busy low within 42 ns, <=1.25 us
// [R8] single update finishes within 500 ns
// [R9] output driven within 3 us of busy
// [R10] load waits busy high and 20 ns
// [R11] load low 10 ns; outputs within 3 us
// [R12] clear asynchronous, level, active low
// [R13] reset 30 ns; busy low <=400 us
// [R14] busy open-drain output, also read
// [R15] sclk no faster than 50 MHz
// [R16] auto update while load inactive
// [R17] load copies selected register to all
// [R18] msb first; short frames ignored
module dac_link_device import dac_link_pkg::*; #(
  parameter int RESET_CYCLES = RESET_BUSY_CYCLES,
  parameter int INIT_CYCLES = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  dac_link_if.device link,
  output logic [CHANNELS*DATA_BITS-1:0] chan_out,
  output logic outputs_cleared,
  output logic busy_seen
);
  typedef enum {ST_INIT, ST_IDLE, ST_UPDATE} dev_state_t;
  logic [5:0] pins;
  logic frame_s, sclk_s, sdi_s, load_s, rst_pin_s, busy_s;
  logic sclk_d, frame_d;
  logic [FRAME_BITS-1:0] shift;
  logic [4:0] nbits;
  logic [DATA_BITS-1:0] reg_first [CHANNELS];
  logic [DATA_BITS-1:0] reg_second [CHANNELS];
  logic [CHANNELS-1:0] sel_second;
  logic [FRAME_BITS-1:0] rb_word;
  logic rb_armed;
  logic [CHAN_BITS-1:0] upd_chan;
  logic [18:0] timer;
  dev_state_t state;
  logic sclk_fall, sclk_rise, frame_rise, frame_fall, word_ok;
  logic [CHAN_BITS-1:0] w_chan;

  // =====================================================
  // pin synchronisers
  pin_sync #(.WIDTH(6)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({link.frame_n, link.sclk, link.serial_in,
               link.load_outputs_n, link.dev_reset_n, link.busy}),
    .sync_out(pins)
  );
  assign {frame_s, sclk_s, sdi_s, load_s, rst_pin_s, busy_s} = pins;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b1;
      frame_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      frame_d <= frame_s;
    end
  end
  assign sclk_fall = sclk_d && !sclk_s && !frame_s;
  assign sclk_rise = !sclk_d && sclk_s && !frame_s;
  assign frame_rise = !frame_d && frame_s;
  assign frame_fall = frame_d && !frame_s;
  // [R18] full frames only
  assign word_ok = frame_rise && (nbits == 5'(FRAME_BITS));
  assign w_chan = shift[CHAN_MSB:CHAN_LSB];

  // =====================================================
  // shift register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift <= '0;
      nbits <= '0;
    end else if (frame_s) begin
      if (!frame_rise) nbits <= '0;
    end else if (sclk_fall) begin
      // [R1] msb first capture
      shift <= {shift[FRAME_BITS-2:0], sdi_s};
      if (nbits != 5'h1f) nbits <= nbits + 5'h01;
    end
  end

  // =====================================================
  // readback: armed by a readback frame, shifted in the next
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_word <= '0;
      rb_armed <= 1'b0;
      link.serial_out <= 1'b0;
    end else begin
      if (word_ok && shift[KIND_MSB:KIND_LSB] == KIND_READBACK) begin
        rb_armed <= 1'b1;
        rb_word <= '0;
        if (w_chan < 6'(CHANNELS))
          rb_word[DATA_BITS-1:0] <= sel_second[w_chan] ?
            reg_second[w_chan] : reg_first[w_chan];
      end else if (word_ok) begin
        rb_armed <= 1'b0;
      end
      // [R3] launch on rising edge; the clock idles high, so the first
      // rise follows the first fall and the msb must be out at frame start
      if (rb_armed && frame_fall) begin
        link.serial_out <= rb_word[FRAME_BITS-1];
        rb_word <= {rb_word[FRAME_BITS-2:0], 1'b0};
      end else if (rb_armed && sclk_rise) begin
        link.serial_out <= rb_word[FRAME_BITS-1];
        rb_word <= {rb_word[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // =====================================================
  // register writes, selects, update sequencing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_INIT;
      timer <= '0;
      upd_chan <= '0;
      sel_second <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        reg_first[i] <= '0;
        reg_second[i] <= '0;
      end
    end else if (!rst_pin_s) begin
      // [R13] hold busy through reset
      state <= ST_INIT;
      timer <= '0;
      sel_second <= '0;
      for (int i = 0; i < CHANNELS; i++) begin
        reg_first[i] <= '0;
        reg_second[i] <= '0;
      end
    end else begin
      case (state)
        ST_INIT: begin
          timer <= timer + 19'h1;
          if (int'(timer) >= INIT_CYCLES - 1 ||
              int'(timer) >= RESET_CYCLES - 1) state <= ST_IDLE;
        end
        ST_IDLE: begin
          // [R5] act on frame_n rise
          if (word_ok && w_chan < 6'(CHANNELS)) begin
            case (shift[KIND_MSB:KIND_LSB])
              KIND_WRITE_FIRST: reg_first[w_chan] <= shift[15:0];
              KIND_WRITE_SECOND: reg_second[w_chan] <= shift[15:0];
              KIND_SELECT: sel_second[w_chan] <= shift[0];
              default: ;
            endcase
            if (shift[KIND_MSB:KIND_LSB] != KIND_READBACK) begin
              upd_chan <= w_chan;
              timer <= '0;
              state <= ST_UPDATE;
            end
          end
        end
        ST_UPDATE: begin
          // [R8] bounded update cycle
          timer <= timer + 19'h1;
          if (int'(timer) >= UPDATE_CYCLES - 2) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // [R7] [R14] open-drain busy pull-down
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.busy_dev_o <= 1'b0;
      link.busy_dev_oe_n <= 1'b0;
      busy_seen <= 1'b0;
    end else begin
      link.busy_dev_o <= 1'b0;
      link.busy_dev_oe_n <= !(state != ST_IDLE || word_ok || !rst_pin_s);
      busy_seen <= !busy_s;
    end
  end

  // =====================================================
  // channel outputs
  always_ff @(posedge core_clk or negedge link.clear_outputs_n) begin
    if (!link.clear_outputs_n) begin
      // [R12] asynchronous clear
      chan_out <= '0;
      outputs_cleared <= 1'b1;
    end else if (!rst_n) begin
      chan_out <= '0;
      outputs_cleared <= 1'b1;
    end else if (!rst_pin_s) begin
      // [R13] device reset returns every output to zero
      chan_out <= '0;
      outputs_cleared <= 1'b0;
    end else begin
      outputs_cleared <= 1'b0;
      if (!load_s) begin
        // [R11] [R17] load every channel at once
        for (int i = 0; i < CHANNELS; i++)
          chan_out[i*DATA_BITS +: DATA_BITS] <=
            sel_second[i] ? reg_second[i] : reg_first[i];
      end else if (state == ST_UPDATE &&
                   int'(timer) == UPDATE_CYCLES - 2) begin
        // [R9] [R16] automatic update on completion
        chan_out[int'(upd_chan)*DATA_BITS +: DATA_BITS] <=
          sel_second[upd_chan] ? reg_second[upd_chan] : reg_first[upd_chan];
      end
    end
  end
endmodule

// ---- rtl/dac_link_host.sv ----
`timescale 1ns/1ps
module dac_link_host import dac_link_pkg::*; #(
  parameter int HALF_CYCLES = SCLK_HALF_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  dac_link_if.host link,
  input wire logic req_valid,
  input wire logic [FRAME_BITS-1:0] req_word,
  input wire logic load_req,
  input wire logic clear_req,
  input wire logic dev_reset_req,
  output logic req_ready,
  output logic [FRAME_BITS-1:0] rsp_word,
  output logic rsp_valid
);
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_END, H_GAP, H_LOAD, H_RST}
    host_state_t;
  host_state_t state;
  logic [FRAME_BITS-1:0] tx, rx;
  logic [4:0] nbits;
  logic [7:0] cnt;
  logic [1:0] busy_sync;
  logic load_pend, rb_next, rb_cur;
  int gap;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_sync <= 2'h0;
    else busy_sync <= {busy_sync[0], link.busy};
  end

  assign link.busy_host_o = 1'b0;
  assign link.busy_host_oe_n = 1'b1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      link.frame_n <= 1'b1;
      link.sclk <= 1'b1;
      link.serial_in <= 1'b0;
      link.load_outputs_n <= 1'b1;
      link.clear_outputs_n <= 1'b1;
      link.dev_reset_n <= 1'b1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_word <= '0;
      tx <= '0;
      rx <= '0;
      nbits <= '0;
      cnt <= '0;
      load_pend <= 1'b0;
      rb_next <= 1'b0;
      rb_cur <= 1'b0;
      gap <= 0;
    end else begin
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      link.clear_outputs_n <= !clear_req;
      case (state)
        H_IDLE: begin
          if (dev_reset_req) begin
            link.dev_reset_n <= 1'b0;
            cnt <= '0;
            state <= H_RST;
          end else if (load_pend && busy_sync[1]) begin
            // [R10] load only with busy high
            link.load_outputs_n <= 1'b0;
            load_pend <= 1'b0;
            cnt <= '0;
            state <= H_LOAD;
          end else if (req_valid && busy_sync[1]) begin
            req_ready <= 1'b1;
            tx <= req_word;
            rb_cur <= rb_next;
            rb_next <= (req_word[KIND_MSB:KIND_LSB] == KIND_READBACK);
            link.frame_n <= 1'b0;
            link.serial_in <= req_word[FRAME_BITS-1];
            nbits <= '0;
            cnt <= '0;
            state <= H_HIGH;
          end
        end
        // [R15] sclk half period from divider
        H_HIGH: begin
          cnt <= cnt + 8'h01;
          if (int'(cnt) >= HALF_CYCLES - 1) begin
            cnt <= '0;
            link.sclk <= 1'b0;
            rx <= {rx[FRAME_BITS-2:0], link.serial_out};
            nbits <= nbits + 5'h01;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          cnt <= cnt + 8'h01;
          if (int'(cnt) >= HALF_CYCLES - 1) begin
            cnt <= '0;
            link.sclk <= 1'b1;
            // [R2] data changes on rise, stable at fall
            tx <= {tx[FRAME_BITS-2:0], 1'b0};
            link.serial_in <= tx[FRAME_BITS-2];
            if (nbits == 5'(FRAME_BITS)) state <= H_END;
            else state <= H_HIGH;
          end
        end
        H_END: begin
          // [R4] [R5] raise frame after 24th fall
          link.frame_n <= 1'b1;
          if (rb_cur) begin
            rsp_word <= rx;
            rsp_valid <= 1'b1;
          end
          // [R6] longer gap before readback data
          gap <= rb_next ? READBACK_GAP_CYCLES + 2 : FRAME_GAP_CYCLES + 4;
          cnt <= '0;
          state <= H_GAP;
        end
        H_GAP: begin
          cnt <= cnt + 8'h01;
          if (int'(cnt) >= gap) state <= H_IDLE;
        end
        H_LOAD: begin
          // [R11] hold load low
          cnt <= cnt + 8'h01;
          if (int'(cnt) >= LOAD_LOW_CYCLES) begin
            link.load_outputs_n <= 1'b1;
            state <= H_IDLE;
          end
        end
        H_RST: begin
          // [R13] reset pulse width
          cnt <= cnt + 8'h01;
          if (int'(cnt) >= RESET_LOW_CYCLES + 1) begin
            link.dev_reset_n <= 1'b1;
            cnt <= '0;
            gap <= 8;
            state <= H_GAP;
          end
        end
        default: state <= H_IDLE;
      endcase
      // a request in the cycle a load starts is kept, not lost
      if (load_req) load_pend <= 1'b1;
    end
  end
endmodule

// ---- sim/dac_link_checker.sv ----
`timescale 1ns/1ps
module dac_link_checker import dac_link_pkg::*; #(
  parameter int BUSY_MAX = UPDATE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic load_outputs_n,
  input wire logic dev_reset_n,
  input wire logic busy_dev_o,
  input wire logic busy_dev_oe_n,
  input wire logic busy
);
  // ======================================
  // frame tracking
  logic sclk_q;
  logic fall;
  logic [5:0] falls;
  logic [23:0] word;
  logic [15:0] low_cnt;
  assign fall = sclk_q && !sclk && !frame_n;
  // word rebuilt here so busy is only demanded after real writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
      falls <= 6'h0;
      word <= 24'h0;
      low_cnt <= 16'h0;
    end else begin
      sclk_q <= sclk;
      falls <= frame_n ? 6'h0 : falls + {5'h0, fall};
      word <= fall ? {word[22:0], serial_in} : word;
      low_cnt <= busy ? 16'h0 : low_cnt + 16'h1;
    end
  end
  // ======================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_fall24;
    $rose(frame_n) |-> falls == 6'd24;
  endproperty
  a_fall24: assert property (p_fall24)
    else $error("frame closed early");
  property p_sdi;
    fall |-> $stable(serial_in);
  endproperty
  a_sdi: assert property (p_sdi)
    else $error("serial_in moved at fall");
  property p_sdo;
    !frame_n && $changed(serial_out) |-> sclk;
  endproperty
  a_sdo: assert property (p_sdo)
    else $error("serial_out moved while clock low");
  property p_bfall;
    $rose(frame_n) && !word[23] && word[21:16] < 6'd40 |-> ##[1:5] !busy;
  endproperty
  a_bfall: assert property (p_bfall)
    else $error("busy late after write");
  property p_blen;
    low_cnt <= 16'(BUSY_MAX);
  endproperty
  a_blen: assert property (p_blen)
    else $error("busy held low too long");
  property p_odrain;
    !busy_dev_oe_n |-> !busy_dev_o && !busy;
  endproperty
  a_odrain: assert property (p_odrain)
    else $error("busy driven high");
  property p_load_outputs_n;
    $fell(load_outputs_n) |-> busy;
  endproperty
  a_load_outputs_n: assert property (p_load_outputs_n)
    else $error("load while busy");
  property p_rst;
    $fell(dev_reset_n) |-> ##[1:13] !busy;
  endproperty
  a_rst: assert property (p_rst)
    else $error("no busy on device reset");
  c_write: cover property ($rose(frame_n) ##[1:5] !busy);
  c_load: cover property ($fell(load_outputs_n));
  c_reset: cover property ($fell(dev_reset_n));
endmodule

// ---- sim/dac_serial_frame_and_load_control_tb.sv ----
`timescale 1ns/1ps
module dac_serial_frame_and_load_control_tb import dac_link_pkg::*; ;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic load_req = 1'b0;
  logic clear_req = 1'b0;
  logic dev_reset_req = 1'b0;
  logic [23:0] req_word = 24'h0;
  logic req_ready, rsp_valid, cleared, busy_seen;
  logic [23:0] rsp_word;
  logic [639:0] chan_out, chan_out_b;
  int error_cnt = 0;
  int check_count = 0;
  int rsp_cnt = 0;
  int first[40], second[40], sel[40], cur[40];
  dac_link_if link();
  dac_link_if link_b();
  dac_link_host #(.HALF_CYCLES(4)) i_dac_link_host (.core_clk(core_clk),
    .rst_n(rst_n), .link(link), .req_valid(req_valid),
    .req_word(req_word), .load_req(load_req), .clear_req(clear_req),
    .dev_reset_req(dev_reset_req), .req_ready(req_ready),
    .rsp_word(rsp_word), .rsp_valid(rsp_valid));
  dac_link_device #(.RESET_CYCLES(32), .INIT_CYCLES(16)) i_dac_link_device (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .chan_out(chan_out),
    .outputs_cleared(cleared), .busy_seen(busy_seen));
  // second device faces the bench, which can cut frames short
  dac_link_device #(.RESET_CYCLES(32), .INIT_CYCLES(16)) i_dac_link_device_b (
    .core_clk(core_clk), .rst_n(rst_n), .link(link_b),
    .chan_out(chan_out_b), .outputs_cleared(), .busy_seen());
  dac_link_checker i_dac_link_checker (.core_clk(core_clk), .rst_n(rst_n),
    .frame_n(link.frame_n), .sclk(link.sclk), .serial_in(link.serial_in),
    .serial_out(link.serial_out), .load_outputs_n(link.load_outputs_n),
    .dev_reset_n(link.dev_reset_n), .busy_dev_o(link.busy_dev_o),
    .busy_dev_oe_n(link.busy_dev_oe_n), .busy(link.busy));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (rsp_valid === 1'b1) rsp_cnt++;
  end
  // ======================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(negedge core_clk);
    n--;
    if (n < 0) begin
      error_cnt++;
      $display("CHECK FAILED %0t wait timed out", $time);
      final_report();
    end
  endtask
  task automatic send(input logic [23:0] w);
    int n;
    n = 2000;
    req_word = w;
    req_valid = 1'b1;
    do tick(n); while (req_ready !== 1'b1);
    req_valid = 1'b0;
  endtask
  task automatic frame(input logic [1:0] k, input int ch, input logic [15:0] d);
    int n;
    n = 800;
    send({k, 6'(ch), d});
    while (link.frame_n === 1'b1) tick(n);
    while (link.frame_n !== 1'b1) tick(n);
    if (ch < CHANNELS) begin
      if (k == KIND_WRITE_FIRST) first[ch] = d;
      if (k == KIND_WRITE_SECOND) second[ch] = d;
      if (k == KIND_SELECT) sel[ch] = d[0];
      if (k != KIND_READBACK) cur[ch] = sel[ch] ? second[ch] : first[ch];
    end
  endtask
  // outputs may lag busy release by up to 3 us
  task automatic check_all;
    logic [639:0] m;
    for (int i = 0; i < CHANNELS; i++) m[16*i+:16] = cur[i][15:0];
    for (int k = 0; k < 400 && chan_out !== m; k++) @(negedge core_clk);
    for (int i = 0; i < CHANNELS; i++) chk(chan_out[16*i+:16], m[16*i+:16]);
  endtask
  task automatic pulse_load;
    int n;
    n = 300;
    load_req = 1'b1;
    @(negedge core_clk);
    load_req = 1'b0;
    while (link.load_outputs_n !== 1'b0) tick(n);
    while (link.load_outputs_n !== 1'b1) tick(n);
    for (int i = 0; i < CHANNELS; i++) cur[i] = sel[i] ? second[i] : first[i];
  endtask
  task automatic bang(input logic [23:0] w, input int nb);
    link_b.frame_n = 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      link_b.serial_in = w[i];
      repeat (4) @(negedge core_clk);
      link_b.sclk = 1'b0;
      repeat (4) @(negedge core_clk);
      link_b.sclk = 1'b1;
    end
    link_b.frame_n = 1'b1;
    link_b.serial_in = ~link_b.serial_in;
  endtask
  // ======================================
  // main sequence
  initial begin
    logic [15:0] d;
    int n;
    void'($urandom(71));
    link_b.frame_n = 1'b1;
    link_b.sclk = 1'b1;
    link_b.serial_in = 1'b0;
    link_b.load_outputs_n = 1'b1;
    link_b.clear_outputs_n = 1'b1;
    link_b.dev_reset_n = 1'b1;
    link_b.busy_host_o = 1'b1;
    link_b.busy_host_oe_n = 1'b1;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    n = 200;
    while (link.busy !== 1'b1) tick(n);
    check_all();
    for (int i = 0; i < 6; i++) begin
      frame(KIND_WRITE_FIRST, i < 2 ? i * 39 : $urandom % 40, 16'($urandom));
      check_all();
    end
    frame(KIND_WRITE_SECOND, 7, 16'($urandom));
    check_all();
    frame(KIND_SELECT, 7, 16'h1);
    check_all();
    frame(KIND_WRITE_FIRST, 7, 16'h1234);
    check_all();
    frame(KIND_READBACK, 39, 16'h0);
    frame(KIND_WRITE_FIRST, 63, 16'hffff);
    for (int k = 0; k < 50 && rsp_cnt == 0; k++) @(negedge core_clk);
    chk(16'(rsp_cnt), 16'h1);
    d = 16'(sel[39] ? second[39] : first[39]);
    chk(rsp_word[15:0], d);
    chk({8'h0, rsp_word[23:16]}, 16'h0);
    check_all();
    // clear zeroes the outputs but keeps the registers, so a load restores
    clear_req = 1'b1;
    for (int k = 0; k < 16 && cleared !== 1'b1; k++) @(negedge core_clk);
    chk({15'h0, cleared}, 16'h1);
    clear_req = 1'b0;
    for (int k = 0; k < 20 && cleared !== 1'b0; k++) @(negedge core_clk);
    chk({15'h0, cleared}, 16'h0);
    for (int i = 0; i < CHANNELS; i++) cur[i] = 0;
    check_all();
    pulse_load();
    check_all();
    // the host only takes a reset request when idle, so hold it until seen
    n = 60;
    dev_reset_req = 1'b1;
    while (link.dev_reset_n !== 1'b0) tick(n);
    dev_reset_req = 1'b0;
    while (busy_seen !== 1'b1) tick(n);
    n = 200;
    while (link.busy !== 1'b1) tick(n);
    for (int i = 0; i < CHANNELS; i++) begin
      first[i] = 0;
      second[i] = 0;
      sel[i] = 0;
      cur[i] = 0;
    end
    check_all();
    d = 16'($urandom) | 16'h1;
    frame(KIND_WRITE_FIRST, 20, d);
    check_all();
    bang({KIND_WRITE_FIRST, 6'd5, d}, 12);
    for (int k = 0; k < 400 && chan_out_b[80+:16] === 16'h0; k++)
      @(negedge core_clk);
    chk(chan_out_b[80+:16], 16'h0);
    bang({KIND_WRITE_FIRST, 6'd5, d}, 24);
    for (int k = 0; k < 400 && chan_out_b[80+:16] !== d; k++)
      @(negedge core_clk);
    chk(chan_out_b[80+:16], d);
    final_report();
  end
endmodule
